// ==== hdl/sadc_pkg.sv ====
// Notes on behaviour
// - low register: result bits 1:0, done, busy
// - high register holds result bits nine to two
// - low register bits 3:0 read unstable
// - reading high register clears done flag
// - busy set at start, cleared at single-shot finish or abort
// - standby also clears the busy flag
// - single-shot: start bit converts selected channel
// - completion stores result, sets done, raises irq
// - start bit self-clears once conversion begins
// - repeat mode: start bit begins repeated conversions
// - repeat restarts right after each completion
// - disable code aborts, result not stored
// - restart clears done, keeps old result
// - standby aborts and resets both control registers
// - after standby stay idle until new start
// - standby disconnects the reference ladder
// - single-shot conversion begins right after start
// - control one field layout and channel codes
// - mode codes: off, single, reserved, repeat
// - time codes select 39 to 1248 cycles
// - ladder bit: during conversion or always
package sadc_pkg;

    // ------------------------------------------------------------
    // register map: indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_ONE  = 8'h1c;  // converter_control_one
    localparam logic [7:0] IDX_CTRL_TWO  = 8'h1d;  // converter_control_two
    localparam logic [7:0] IDX_RES_LOW   = 8'h1e;  // result_low_status_reg
    localparam logic [7:0] IDX_RES_HIGH  = 8'h1f;  // result_high_reg
    localparam logic [7:0] ADDR_CTRL_ONE = 8'(IDX_CTRL_ONE * 4);
    localparam logic [7:0] ADDR_CTRL_TWO = 8'(IDX_CTRL_TWO * 4);
    localparam logic [7:0] ADDR_RES_LOW  = 8'(IDX_RES_LOW * 4);
    localparam logic [7:0] ADDR_RES_HIGH = 8'(IDX_RES_HIGH * 4);

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned C1_START  = 7;  // conversion_start_bit
    localparam int unsigned C1_MODE   = 5;  // operating_mode_field, 2 bits
    localparam int unsigned C1_INDIS  = 4;  // analog_input_disable
    localparam int unsigned C1_CHAN   = 0;  // channel_select_field, 4 bits
    localparam int unsigned C2_LADDER = 5;  // ladder_always_connected
    localparam int unsigned C2_FIXONE = 4;  // always written as one
    localparam int unsigned C2_TIME   = 1;  // conversion time code, 3 bits
    localparam int unsigned RL_RES    = 6;  // result bits 1:0
    localparam int unsigned RL_DONE   = 5;  // conversion_done_flag
    localparam int unsigned RL_BUSY   = 4;  // conversion_busy_flag
    localparam logic [7:0]  C1_RESET  = 8'h10;
    localparam logic [7:0]  C2_RESET  = 8'h00;
    localparam logic [9:0]  RES_RESET = 10'h000;
    localparam logic [3:0]  LFSR_SEED = 4'h1;

    // ------------------------------------------------------------
    // conversion timing in system clock cycles
    // ------------------------------------------------------------
    localparam int unsigned RES_W       = 10;  // result width
    localparam logic [10:0] CYC_39      = 11'd39;
    localparam logic [10:0] CYC_78      = 11'd78;
    localparam logic [10:0] CYC_156     = 11'd156;
    localparam logic [10:0] CYC_312     = 11'd312;
    localparam logic [10:0] CYC_624     = 11'd624;
    localparam logic [10:0] CYC_1248    = 11'd1248;
    localparam int unsigned TRIAL_SHIFT = 4;   // unused; the timer takes trial slot = time / 11
    localparam logic [3:0]  LAST_TRIAL  = 4'd10;
    localparam logic [3:0]  TRIAL_SAT   = 4'd11;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_RSVD   = 2'b10,
        MODE_REPEAT = 2'b11
    } sadc_mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sadc_state_t;

    // time code to cycle count; reserved codes take the longest time
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        case (code)
            3'b000:  conv_cycles = CYC_39;
            3'b010:  conv_cycles = CYC_78;
            3'b011:  conv_cycles = CYC_156;
            3'b100:  conv_cycles = CYC_312;
            3'b101:  conv_cycles = CYC_624;
            3'b110:  conv_cycles = CYC_1248;
            default: conv_cycles = CYC_1248;
        endcase
    endfunction

endpackage

// ==== hdl/sadc_timer.sv ====
// ----------------------------------------------------------------
// conversion timer: sample slot, ten trial steps, end pulse
// ----------------------------------------------------------------
module sadc_timer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       abort,
    input  wire logic [2:0] time_code,
    output logic            step,
    output logic            fin,
    output logic            sampling
);
    typedef struct packed {
        logic        active;  // counting a conversion
        logic [10:0] cnt;     // cycles since start
        logic [10:0] total;   // cycles for this conversion
        logic [6:0]  tlen;    // trial slot length minus one, eleven slots
        logic [6:0]  sub;     // cycle within slot
        logic [3:0]  trial;   // slot index, zero is sampling
        logic        step;
        logic        fin;
    } sadc_tmr_t;

    sadc_tmr_t q, d;
    logic [10:0] tot_c;

    // next state; abort beats go so standby wins
    always_comb begin
        d      = q;
        d.step = 1'b0;
        d.fin  = 1'b0;
        tot_c  = sadc_pkg::conv_cycles(time_code);
        if (abort) begin
            d.active = 1'b0;
        end else if (go) begin
            d.active = 1'b1;
            d.cnt    = 11'd0;
            d.sub    = 7'd0;
            d.trial  = 4'd0;
            d.total  = tot_c;
            // eleven equal slots: slowest code still fits seven bits, and the
            // fastest code leaves three cycles per decision for pin sync lag
            d.tlen   = 7'((tot_c / 11'(sadc_pkg::TRIAL_SAT)) - 11'd1);
        end else if (q.active) begin
            d.cnt = q.cnt + 11'd1;
            if (q.sub == q.tlen) begin
                d.sub = 7'd0;
                if (q.trial != sadc_pkg::TRIAL_SAT) begin
                    d.trial = q.trial + 4'd1;
                end
                // steps only in slots one to ten
                d.step = (q.trial != 4'd0) && (q.trial <= sadc_pkg::LAST_TRIAL);
            end else begin
                d.sub = q.sub + 7'd1;
            end
            if (q.cnt == q.total - 11'd1) begin
                d.fin    = 1'b1;
                d.active = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign step     = q.step;
    assign fin      = q.fin;
    assign sampling = q.active && (q.trial == 4'd0);
endmodule // sadc_timer

// ==== hdl/sadc_sar.sv ====
// ----------------------------------------------------------------
// successive approximation register, one decision per step
// ----------------------------------------------------------------
module sadc_sar (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       step,
    input  wire logic       cmp,
    output logic [9:0]      code
);
    typedef struct packed {
        logic [9:0] code;  // trial code driven to the ladder
        logic [3:0] idx;   // bit under trial
    } sadc_sar_t;

    sadc_sar_t q, d;

    // cmp high means input is at or above the trial level: keep bit
    always_comb begin
        d = q;
        if (go) begin
            d.code = 10'h200;
            d.idx  = 4'd9;
        end else if (step) begin
            if (!cmp) begin
                d.code[q.idx] = 1'b0;
            end
            if (q.idx != 4'd0) begin
                d.idx               = q.idx - 4'd1;
                d.code[q.idx - 4'd1] = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign code = q.code;
endmodule // sadc_sar

// ==== hdl/sadc_top.sv ====
// ----------------------------------------------------------------
// converter sequencer with apb register file
// ----------------------------------------------------------------
module sadc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        standby,
    input  wire logic        cmp_pin,
    output logic      [3:0]  channel_sel,
    output logic             input_disable,
    output logic             ladder_on,
    output logic             sample_hold,
    output logic      [9:0]  dac_code,
    output logic             conversion_done_irq
);

    // ------------------------------------------------------------
    // state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  start;    // conversion_start_bit
        sadc_pkg::sadc_mode_t  mode;     // operating_mode_field
        logic                  indis;    // analog_input_disable
        logic [3:0]            chan;     // channel_select_field
        logic                  ladder;   // ladder_always_connected
        logic [2:0]            tsel;     // conversion time code
        logic [9:0]            result;   // last stored result
        logic                  done;     // conversion_done_flag
        logic                  busy;     // conversion_busy_flag
        sadc_pkg::sadc_state_t state;
        logic                  irq;      // one-cycle done pulse
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic [3:0]            lfsr;     // noise for unused bits
        logic                  cmp_s1;   // sync stage one
        logic                  cmp_s2;   // sync stage two
        logic                  sample;
        logic                  ladder_on;
    } sadc_top_t;

    sadc_top_t q, d;

    logic       go_c;       // start timer and sar
    logic       abort_c;    // drop conversion in flight
    logic       acc_c;      // apb access completes
    logic       setup_c;    // apb setup cycle
    logic       tmr_step;   // sar decision strobe
    logic       tmr_fin;    // conversion time elapsed
    logic       tmr_samp;   // sampling slot
    logic [9:0] sar_code;   // current trial code

    // ------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------
    sadc_timer u_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .go        (go_c),
        .abort     (abort_c),
        .time_code (q.tsel),
        .step      (tmr_step),
        .fin       (tmr_fin),
        .sampling  (tmr_samp)
    );

    sadc_sar u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .go      (go_c),
        .step    (tmr_step),
        .cmp     (q.cmp_s2),
        .code    (sar_code)
    );

    // ------------------------------------------------------------
    // read mux, shared by the setup-cycle capture
    // ------------------------------------------------------------
    function automatic logic [32:0] rd_mux(input sadc_top_t s, input logic [7:0] a);
        rd_mux = '0;
        case (a)
            sadc_pkg::ADDR_CTRL_ONE: begin
                rd_mux[7:0] = {s.start, s.mode, s.indis, s.chan};
            end
            sadc_pkg::ADDR_CTRL_TWO: begin
                // top two bits unspecified, read as zero
                rd_mux[7:0] = {2'b00, s.ladder, 1'b1, s.tsel, 1'b0};
            end
            sadc_pkg::ADDR_RES_LOW: begin
                // low nibble is deliberately noisy
                rd_mux[7:0] = {s.result[1:0], s.done, s.busy, s.lfsr};
            end
            sadc_pkg::ADDR_RES_HIGH: begin
                rd_mux[7:0] = s.result[9:2];
            end
            default: begin
                rd_mux[32] = 1'b1;  // unmapped: error, data zero
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d         = q;
        go_c      = 1'b0;
        abort_c   = 1'b0;
        setup_c   = psel && !penable;
        acc_c     = psel && penable && q.pready;
        d.irq     = 1'b0;
        d.cmp_s1  = cmp_pin;
        d.cmp_s2  = q.cmp_s1;
        d.lfsr    = {q.lfsr[2:0], q.lfsr[3] ^ q.lfsr[2]};
        d.sample  = tmr_samp;

        // zero-wait slave: answer in the first access cycle
        d.pready = setup_c;
        if (setup_c) begin
            {d.pslverr, d.prdata} = rd_mux(q, paddr);
        end else begin
            d.pslverr = 1'b0;
        end

        // reading the high result clears done; a set below wins
        if (acc_c && !pwrite && paddr == sadc_pkg::ADDR_RES_HIGH) begin
            d.done = 1'b0;
        end

        // sequencer
        case (q.state)
            sadc_pkg::ST_IDLE: begin
                if (q.start) begin
                    d.start = 1'b0;
                    if (q.mode == sadc_pkg::MODE_SINGLE ||
                        q.mode == sadc_pkg::MODE_REPEAT) begin
                        go_c    = 1'b1;
                        d.busy  = 1'b1;
                        d.done  = 1'b0;
                        d.state = sadc_pkg::ST_CONV;
                    end
                end
            end
            sadc_pkg::ST_CONV: begin
                d.start = 1'b0;  // restart while busy is ignored
                if (q.mode == sadc_pkg::MODE_OFF ||
                    q.mode == sadc_pkg::MODE_RSVD) begin
                    abort_c = 1'b1;
                    d.busy  = 1'b0;
                    d.state = sadc_pkg::ST_IDLE;
                end else if (tmr_fin) begin
                    d.result = sar_code;
                    d.done   = 1'b1;
                    d.irq    = 1'b1;
                    if (q.mode == sadc_pkg::MODE_REPEAT) begin
                        go_c = 1'b1;
                    end else begin
                        d.busy  = 1'b0;
                        d.state = sadc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                d.state = sadc_pkg::ST_IDLE;
            end
        endcase

        // register writes take effect at the completing access edge
        if (acc_c && pwrite) begin
            case (paddr)
                sadc_pkg::ADDR_CTRL_ONE: begin
                    d.start = pwdata[sadc_pkg::C1_START];
                    d.mode  = sadc_pkg::sadc_mode_t'(pwdata[sadc_pkg::C1_MODE +: 2]);
                    d.indis = pwdata[sadc_pkg::C1_INDIS];
                    d.chan  = pwdata[sadc_pkg::C1_CHAN +: 4];
                end
                sadc_pkg::ADDR_CTRL_TWO: begin
                    d.ladder = pwdata[sadc_pkg::C2_LADDER];
                    d.tsel   = pwdata[sadc_pkg::C2_TIME +: 3];
                end
                default: begin
                    d.start = d.start;  // read-only or unmapped
                end
            endcase
        end

        // standby overrides everything and holds the block at reset
        if (standby) begin
            abort_c  = 1'b1;
            go_c     = 1'b0;
            {d.start, d.mode, d.indis, d.chan} = sadc_pkg::C1_RESET;
            d.ladder = sadc_pkg::C2_RESET[sadc_pkg::C2_LADDER];
            d.tsel   = sadc_pkg::C2_RESET[sadc_pkg::C2_TIME +: 3];
            d.busy   = 1'b0;
            d.done   = 1'b0;
            d.irq    = 1'b0;
            d.result = sadc_pkg::RES_RESET;  // earlier results are lost
            d.state  = sadc_pkg::ST_IDLE;
        end

        // ladder draws current only when needed, never in standby
        d.ladder_on = !standby && (d.ladder || d.busy);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.mode   <= sadc_pkg::MODE_OFF;
            q.indis  <= sadc_pkg::C1_RESET[sadc_pkg::C1_INDIS];
            q.lfsr   <= sadc_pkg::LFSR_SEED;
            q.state  <= sadc_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign channel_sel         = q.chan;
    assign input_disable       = q.indis;
    assign ladder_on           = q.ladder_on;
    assign sample_hold         = q.sample;
    assign dac_code            = sar_code;
    assign conversion_done_irq = q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic rh_read_c;  // completing read of the high result
    assign rh_read_c = acc_c && !pwrite && paddr == sadc_pkg::ADDR_RES_HIGH;

    a_irq_with_done: assert property (@(posedge pclk) disable iff (!presetn)
        q.irq |-> q.done && $changed(q.irq))
        else $error("irq without done flag");

    a_irq_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        q.irq |=> !q.irq)
        else $error("irq longer than one cycle");

    a_busy_standby: assert property (@(posedge pclk) disable iff (!presetn)
        standby |=> !q.busy && !q.ladder_on && q.state == sadc_pkg::ST_IDLE)
        else $error("busy or ladder left on in standby");

    a_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn)
        standby |=> q.mode == sadc_pkg::MODE_OFF && q.indis && !q.start)
        else $error("control not reset in standby");

    a_start_begins: assert property (@(posedge pclk) disable iff (!presetn)
        q.start && q.state == sadc_pkg::ST_IDLE && q.mode == sadc_pkg::MODE_SINGLE
        && !standby |=> q.busy && !q.done && q.state == sadc_pkg::ST_CONV)
        else $error("single start did not begin");

    a_rh_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rh_read_c && !tmr_fin |=> !q.done)
        else $error("high read did not clear done");

    a_abort_keep: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == sadc_pkg::ST_CONV && q.mode == sadc_pkg::MODE_OFF && !standby
        |=> !q.busy ##1 $stable(q.result))
        else $error("abort stored a result");

    a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !tmr_fin && !standby |=> $stable(q.result))
        else $error("result changed without completion");

    a_repeat_next: assert property (@(posedge pclk) disable iff (!presetn)
        tmr_fin && q.state == sadc_pkg::ST_CONV && q.mode == sadc_pkg::MODE_REPEAT
        && !standby |=> q.busy [*2])
        else $error("repeat did not continue");

    a_busy_state: assert property (@(posedge pclk) disable iff (!presetn)
        q.busy == (q.state == sadc_pkg::ST_CONV))
        else $error("busy flag out of step with sequencer");

    c_single_done: cover property (@(posedge pclk) disable iff (!presetn)
        q.irq && q.mode == sadc_pkg::MODE_SINGLE);
    c_repeat_two: cover property (@(posedge pclk) disable iff (!presetn)
        q.irq ##[1:1000] q.irq);
    c_standby_abort: cover property (@(posedge pclk) disable iff (!presetn)
        q.busy && standby);
endmodule // sadc_top

// ==== bench/sadc_analog_model.sv ====
// ------------------------------------------------------------
// far side: sample-hold, ladder and comparator
// ------------------------------------------------------------
module sadc_analog_model (
    input  wire logic       pclk,
    input  wire logic       sample_hold,
    input  wire logic       ladder_on,
    input  wire logic [3:0] channel_sel,
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] vin [8],
    output logic            cmp_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held = 10'h000;  // charge on the hold capacitor
    logic       last = 1'b0;     // wandering level without reference
    // track the selected input only while the slot is open
    always @(posedge pclk) if (sample_hold) held <= vin[channel_sel[2:0]];
    // no ladder, no reference: output wanders instead of deciding
    always @(posedge pclk) last <= ~last;
    // comparator itself has no clock: it answers the trial code at once
    assign cmp_pin = ladder_on ? (held >= dac_code) : last;
endmodule // sadc_analog_model

// ==== bench/test_sar_adc_sequencer.sv ====
module test_sar_adc_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // stimulus, pulse monitor, register tasks
    // ------------------------------------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, standby = 1'b0, lad;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, cmp_pin, ladder_on, sample_hold, irq, idis;
    logic [3:0]  channel_sel;
    logic [2:0]  code, ch;
    logic [9:0]  dac_code, v, prev;
    logic [9:0]  vin [8];
    int          bad_count = 0, n_compared = 0, cyc = 0, t0, irq_cyc, n_irq = 0;
    always #5 pclk = ~pclk;
    // stamp each done pulse; a pulse held two cycles counts twice
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_cyc <= cyc;
            n_irq <= n_irq + 1;
        end
    end
    sadc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby(standby), .cmp_pin(cmp_pin), .channel_sel(channel_sel),
        .input_disable(idis), .ladder_on(ladder_on), .sample_hold(sample_hold),
        .dac_code(dac_code), .conversion_done_irq(irq));
    sadc_analog_model analog (.pclk(pclk), .sample_hold(sample_hold), .ladder_on(ladder_on),
        .channel_sel(channel_sel), .dac_code(dac_code), .vin(vin), .cmp_pin(cmp_pin));
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd & {24'h0, m}, {24'h0, e});
    endtask
    task automatic wait_irq(input int k);
        repeat (3000) if (n_irq < k) @(posedge pclk);
    endtask
    // reserved time codes fall back to the longest time
    function automatic int cyc_of(input logic [2:0] c);
        int t [8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};
        return t[c];
    endfunction
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h8eac));
        foreach (vin[i]) vin[i] = 10'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(idis), 32'h1);
        rdchk(8'h70, 8'hff, 8'h10);
        rdchk(8'h74, 8'hff, 8'h10);
        rdchk(8'h78, 8'h30, 8'h00);
        prev = 10'h000;
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? 3'b000 : 3'(i + 1);
            ch = 3'($urandom);
            lad = 1'($urandom);
            v = vin[ch];
            apb(1'b1, 8'h74, {2'b00, lad, 1'b1, code, 1'b0});
            apb(1'b1, 8'h70, {4'b1010, 1'b0, ch});
            t0 = cyc;
            rdchk(8'h70, 8'hff, {4'b0010, 1'b0, ch});
            rdchk(8'h7c, 8'hff, prev[9:2]);
            rdchk(8'h78, 8'h30, 8'h10);
            check(32'(channel_sel), 32'(ch));
            check(32'(ladder_on), 32'h1);
            wait_irq(i + 1);
            check(32'(irq_cyc - t0), 32'(cyc_of(code) + 2));
            rdchk(8'h78, 8'hf0, {v[1:0], 6'b100000});
            rdchk(8'h7c, 8'hff, v[9:2]);
            rdchk(8'h78, 8'h20, 8'h00);
            check(32'(ladder_on), 32'(lad));
            check(32'(n_irq), 32'(i + 1));
            prev = v;
        end
        apb(1'b1, 8'h70, {4'b1100, 1'b0, ch});
        repeat (60) @(posedge pclk);
        rdchk(8'h78, 8'h30, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        check(32'(err), 32'h1);
        // repeat: input moves mid-run, later results must follow it
        apb(1'b1, 8'h74, 8'h16);
        apb(1'b1, 8'h70, {4'b1110, 1'b0, ch});
        repeat (80) @(posedge pclk);
        vin[ch] = ~prev;
        wait_irq(7);
        rdchk(8'h7c, 8'hff, prev[9:2]);
        wait_irq(8);
        rdchk(8'h78, 8'h30, 8'h30);
        rdchk(8'h7c, 8'hff, ~prev[9:2]);
        vin[ch] = prev;
        apb(1'b1, 8'h70, {4'b0000, 1'b0, ch});
        repeat (400) @(posedge pclk);
        rdchk(8'h7c, 8'hff, ~prev[9:2]);
        rdchk(8'h78, 8'h10, 8'h00);
        check(32'(n_irq), 32'd8);
        // standby in mid-conversion, then stay quiet after leaving it
        apb(1'b1, 8'h74, 8'h1c);
        apb(1'b1, 8'h70, {4'b1010, 1'b0, ch});
        repeat (100) @(posedge pclk);
        standby <= 1'b1;
        repeat (2) @(posedge pclk);
        check(32'(ladder_on), 32'h0);
        rdchk(8'h78, 8'h30, 8'h00);
        apb(1'b1, 8'h70, {4'b1010, 1'b0, ch});
        rdchk(8'h70, 8'hff, 8'h10);
        rdchk(8'h74, 8'hff, 8'h10);
        standby <= 1'b0;
        repeat (1500) @(posedge pclk);
        rdchk(8'h78, 8'h30, 8'h00);
        check(32'(n_irq), 32'd8);
        finish_test();
    end
endmodule // test_sar_adc_sequencer
